// [inc/dio_pkg.sv]
// constants and types for the drive i/o sampling and mapping block
// assumes a 25 MHz pclk; all counts derive from it
package dio_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int STD_DI_MS = 6;
  localparam int EXT_DI_MS = 20;
  localparam int AO_MS = 24;
  localparam int AO_TEMP_MS = 1000;
  localparam int RO_MS = 100;
  localparam int STD_DI_CYC = CLK_HZ / 1000 * STD_DI_MS;
  localparam int EXT_DI_CYC = CLK_HZ / 1000 * EXT_DI_MS;
  localparam int AO_CYC = CLK_HZ / 1000 * AO_MS;
  localparam int AO_TEMP_CYC = CLK_HZ / 1000 * AO_TEMP_MS;
  localparam int RO_CYC = CLK_HZ / 1000 * RO_MS;
  localparam int CNT_W = 25;

  localparam int N_STD_DI = 7;
  localparam int N_EXT_DI = 9;
  localparam int N_STD_RO = 3;
  localparam int N_RO = 9;
  localparam int N_STD_AO = 2;
  localparam int N_AO = 4;
  localparam int N_QTY = 6;
  localparam int N_WORDS = 32;

  localparam logic [7:0] GRP_INPUT = 8'h01;
  localparam logic [7:0] IDX_STD_DI = 8'h11;
  localparam logic [7:0] IDX_EXT_DI = 8'h28;
  localparam logic [7:0] GRP_STATUS = 8'h03;

  localparam logic [31:0] RO1_PTR_RST = 32'h0003_0D06;
  localparam logic [31:0] RO2_PTR_RST = 32'h0003_0202;
  localparam logic [31:0] RO3_PTR_RST = 32'h8003_0203;

  localparam logic [7:0] OFF_STD_IN = 8'h00;
  localparam logic [7:0] OFF_EXT_IN = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_RO_PTR0 = 8'h10;
  localparam logic [7:0] OFF_RO_OVR = 8'h34;
  localparam logic [7:0] OFF_AO_CFG0 = 8'h40;
  localparam logic [7:0] OFF_AO_VAL0 = 8'h50;

  localparam int CTRL_EXT_DIO = 0;
  localparam int CTRL_EXT_AO = 1;
  localparam int CTRL_AO3_TEMP = 2;
  localparam int CTRL_AO4_TEMP = 3;
  localparam int ST_FAULT = 0;
  localparam int ST_WARN = 1;
  localparam int ST_RO_LSB = 16;
  localparam int OVR_VAL_LSB = 16;

  typedef struct packed {
    logic neg;
    logic [6:0] pad_hi;
    logic [7:0] group;
    logic [7:0] index;
    logic [2:0] pad_lo;
    logic [4:0] bitn;
  } dio_ptr_t;

  typedef struct packed {
    logic [15:0] ovr_val;
    logic [6:0] pad;
    logic ovr_en;
    logic [3:0] filt_shift;
    logic invert;
    logic [2:0] src;
  } dio_ao_cfg_t;

  typedef logic [N_WORDS-1:0][15:0] dio_words_t;
  typedef logic [N_QTY-1:0][15:0] dio_qty_t;
  typedef logic [N_AO-1:0][15:0] dio_ao_vals_t;

  typedef struct packed {
    logic [1:0][N_STD_DI-1:0] std_sync;
    logic [1:0][N_EXT_DI-1:0] ext_sync;
    logic [1:0] link_sync;
    logic [N_STD_DI-1:0] std_in;
    logic [N_EXT_DI-1:0] ext_in;
    logic [CNT_W-1:0] cnt_std;
    logic [CNT_W-1:0] cnt_ext;
    logic [CNT_W-1:0] cnt_ao;
    logic [CNT_W-1:0] cnt_slow;
    logic [CNT_W-1:0] cnt_ro;
    logic [3:0] ctrl;
    logic fault;
    logic warn;
    logic [N_RO-1:0][31:0] ro_ptr;
    logic [N_RO-1:0] ro_ovr_en;
    logic [N_RO-1:0] ro_ovr_val;
    logic [N_RO-1:0] ro_out;
    logic [N_AO-1:0][31:0] ao_cfg;
    logic [N_AO-1:0][15:0] ao_filt;
    logic [N_AO-1:0][15:0] ao_out;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } dio_state_t;
endpackage : dio_pkg

// [logic/dio_map.sv]
// drive i/o sampling and mapping: discrete inputs, relay and analogue outputs
// assumes pins are asynchronous, status words and quantities come from pclk logic
//
// What this block does
// - seven standard plus nine extension discrete inputs
// - pack standard inputs, power-on ack bit 6
// - pointer sign.group.index.bit, negative inverts
// - standard inputs at group 1 index 17
// - extension inputs at group 1 index 40
// - three plus six relays from pointers
// - relay one defaults to brake-open bit
// - relay two defaults to running bit
// - relay three defaults to inverted fault
// - serial master writes relay output directly
// - serial master writes analogue output directly
// - two standard plus two extension analogue outputs
// - analogue outputs optionally inverted and filtered
// - analogue source selectable internal quantity
// - sample inputs every 6 / 20 ms
// - analogue refresh 24 ms, temperature 1000 ms
// - relays refresh every 100 ms
// - fault on extension link loss
// - warning on improper optional i/o use
`timescale 1ns/1ps
module dio_map #(
  parameter int unsigned STD_DI_CYC = dio_pkg::STD_DI_CYC,
  parameter int unsigned EXT_DI_CYC = dio_pkg::EXT_DI_CYC,
  parameter int unsigned AO_CYC = dio_pkg::AO_CYC,
  parameter int unsigned AO_TEMP_CYC = dio_pkg::AO_TEMP_CYC,
  parameter int unsigned RO_CYC = dio_pkg::RO_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [dio_pkg::N_STD_DI-1:0] discrete_input,
  input wire logic [dio_pkg::N_EXT_DI-1:0] extension_input,
  input wire logic ext_link_ok,
  input wire dio_pkg::dio_words_t drive_status,
  input wire dio_pkg::dio_qty_t drive_qty,
  output logic [dio_pkg::N_RO-1:0] relay_output,
  output dio_pkg::dio_ao_vals_t analogue_output,
  output logic extension_link_lost_fault,
  output logic config_warning
);
  localparam dio_pkg::dio_state_t ST_RST = '{
    ro_ptr: '{0: dio_pkg::RO1_PTR_RST,
              1: dio_pkg::RO2_PTR_RST,
              2: dio_pkg::RO3_PTR_RST,
              default: '0},
    default: '0
  };

  dio_pkg::dio_state_t s_r;
  dio_pkg::dio_state_t s_nxt;

  function automatic logic [15:0] ptr_word(
    input dio_pkg::dio_ptr_t p,
    input logic [dio_pkg::N_STD_DI-1:0] sd,
    input logic [dio_pkg::N_EXT_DI-1:0] ex,
    input dio_pkg::dio_words_t w
  );
    logic [15:0] word;
    word = '0;
    if (p.group == dio_pkg::GRP_INPUT && p.index == dio_pkg::IDX_STD_DI) begin
      word = {9'h000, sd};
    end else if (p.group == dio_pkg::GRP_INPUT && p.index == dio_pkg::IDX_EXT_DI) begin
      word = {7'h00, ex};
    end else if (p.group == dio_pkg::GRP_STATUS && p.index < 8'h20) begin
      word = w[p.index[4:0]];
    end
    return word;
  endfunction : ptr_word

  function automatic logic ptr_bit(
    input dio_pkg::dio_ptr_t p,
    input logic [dio_pkg::N_STD_DI-1:0] sd,
    input logic [dio_pkg::N_EXT_DI-1:0] ex,
    input dio_pkg::dio_words_t w
  );
    logic [15:0] word;
    logic v;
    word = ptr_word(p, sd, ex, w);
    v = (p.bitn < 5'h10) ? word[p.bitn[3:0]] : 1'b0;
    return v ^ p.neg;
  endfunction : ptr_bit

  // pointer into extension inputs with extension i/o off is a misuse
  function automatic logic ptr_misuse(input dio_pkg::dio_ptr_t p, input logic ext_on);
    return (p.group == dio_pkg::GRP_INPUT) && (p.index == dio_pkg::IDX_EXT_DI) && !ext_on;
  endfunction : ptr_misuse

  function automatic logic [15:0] ao_step(
    input logic [15:0] tgt,
    input logic [15:0] f,
    input logic [3:0] sh
  );
    logic signed [16:0] diff;
    logic signed [16:0] stepv;
    diff = $signed({tgt[15], tgt}) - $signed({f[15], f});
    stepv = diff >>> sh;
    return f + stepv[15:0];
  endfunction : ao_step

  logic tick_std;
  logic tick_ext;
  logic tick_ao;
  logic tick_slow;
  logic tick_ro;
  logic ext_dio_on;
  logic ext_ao_on;
  logic wr_en;
  logic rd_en;
  logic [5:0] widx;
  logic hit;
  logic [31:0] rd_val;
  logic misuse;
  dio_pkg::dio_ao_cfg_t cfg;
  logic [15:0] tgt;
  logic ao_tick_i;

  always_comb begin
    s_nxt = s_r;
    tick_std = (s_r.cnt_std == dio_pkg::CNT_W'(STD_DI_CYC - 1));
    tick_ext = (s_r.cnt_ext == dio_pkg::CNT_W'(EXT_DI_CYC - 1));
    tick_ao = (s_r.cnt_ao == dio_pkg::CNT_W'(AO_CYC - 1));
    tick_slow = (s_r.cnt_slow == dio_pkg::CNT_W'(AO_TEMP_CYC - 1));
    tick_ro = (s_r.cnt_ro == dio_pkg::CNT_W'(RO_CYC - 1));
    ext_dio_on = s_r.ctrl[dio_pkg::CTRL_EXT_DIO];
    ext_ao_on = s_r.ctrl[dio_pkg::CTRL_EXT_AO];
    widx = paddr[7:2];
    wr_en = psel && penable && s_r.pready && pwrite;
    rd_en = psel && penable && !s_r.pready && !pwrite;
    hit = 1'b1;
    rd_val = '0;
    misuse = 1'b0;
    cfg = '0;
    tgt = '0;
    ao_tick_i = 1'b0;
    if (ce) begin
      s_nxt.std_sync[0] = discrete_input;
      s_nxt.std_sync[1] = s_r.std_sync[0];
      s_nxt.ext_sync[0] = extension_input;
      s_nxt.ext_sync[1] = s_r.ext_sync[0];
      s_nxt.link_sync[0] = ext_link_ok;
      s_nxt.link_sync[1] = s_r.link_sync[0];

      s_nxt.cnt_std = tick_std ? '0 : s_r.cnt_std + 1'b1;
      s_nxt.cnt_ext = tick_ext ? '0 : s_r.cnt_ext + 1'b1;
      s_nxt.cnt_ao = tick_ao ? '0 : s_r.cnt_ao + 1'b1;
      s_nxt.cnt_slow = tick_slow ? '0 : s_r.cnt_slow + 1'b1;
      s_nxt.cnt_ro = tick_ro ? '0 : s_r.cnt_ro + 1'b1;

      // samples held between ticks, status words show the last one
      if (tick_std) begin
        s_nxt.std_in = s_r.std_sync[1];
      end
      if (tick_ext) begin
        s_nxt.ext_in = ext_dio_on ? s_r.ext_sync[1] : '0;
      end

      if (tick_ro) begin
        for (int i = 0; i < dio_pkg::N_RO; i++) begin
          if (i >= dio_pkg::N_STD_RO && !ext_dio_on) begin
            s_nxt.ro_out[i] = 1'b0;
          end else if (s_r.ro_ovr_en[i]) begin
            s_nxt.ro_out[i] = s_r.ro_ovr_val[i];
          end else begin
            s_nxt.ro_out[i] = ptr_bit(s_r.ro_ptr[i], s_r.std_in, s_r.ext_in,
                                      drive_status);
          end
        end
      end

      for (int i = 0; i < dio_pkg::N_AO; i++) begin
        cfg = s_r.ao_cfg[i];
        if (i < dio_pkg::N_STD_AO) begin
          ao_tick_i = tick_ao;
        end else if (s_r.ctrl[dio_pkg::CTRL_AO3_TEMP + i - dio_pkg::N_STD_AO]) begin
          ao_tick_i = tick_slow;
        end else begin
          ao_tick_i = tick_ao;
        end
        tgt = (cfg.src < 3'(dio_pkg::N_QTY)) ? drive_qty[cfg.src] : 16'h0000;
        if (cfg.invert) begin
          tgt = 16'h0000 - tgt;
        end
        if (ao_tick_i) begin
          if (i >= dio_pkg::N_STD_AO && !ext_ao_on) begin
            s_nxt.ao_filt[i] = '0;
            s_nxt.ao_out[i] = '0;
          end else begin
            s_nxt.ao_filt[i] = ao_step(tgt, s_r.ao_filt[i], cfg.filt_shift);
            // a direct write bypasses source, inversion and filter
            s_nxt.ao_out[i] = cfg.ovr_en ? cfg.ovr_val : s_nxt.ao_filt[i];
          end
        end
        if (i >= dio_pkg::N_STD_AO && !ext_ao_on && cfg.ovr_en) begin
          misuse = 1'b1;
        end
      end

      for (int i = 0; i < dio_pkg::N_RO; i++) begin
        if (ptr_misuse(s_r.ro_ptr[i], ext_dio_on)) begin
          misuse = 1'b1;
        end
        if (i >= dio_pkg::N_STD_RO && !ext_dio_on && s_r.ro_ovr_en[i]) begin
          misuse = 1'b1;
        end
      end
      s_nxt.warn = misuse;

      case (paddr[7:0])
        dio_pkg::OFF_STD_IN: rd_val = {25'h0, s_r.std_in};
        dio_pkg::OFF_EXT_IN: rd_val = {23'h0, s_r.ext_in};
        dio_pkg::OFF_CTRL: rd_val = {28'h0, s_r.ctrl};
        dio_pkg::OFF_STATUS: begin
          rd_val = {7'h00, s_r.ro_out, 14'h0000, s_r.warn, s_r.fault};
        end
        dio_pkg::OFF_RO_OVR: rd_val = {7'h00, s_r.ro_ovr_val, 7'h00, s_r.ro_ovr_en};
        default: begin
          if (paddr[1:0] == 2'h0 && widx >= dio_pkg::OFF_RO_PTR0[7:2]
              && widx < dio_pkg::OFF_RO_OVR[7:2]) begin
            rd_val = s_r.ro_ptr[4'(widx - dio_pkg::OFF_RO_PTR0[7:2])];
          end else if (paddr[1:0] == 2'h0 && widx >= dio_pkg::OFF_AO_CFG0[7:2]
                       && widx < dio_pkg::OFF_AO_VAL0[7:2]) begin
            rd_val = s_r.ao_cfg[2'(widx - dio_pkg::OFF_AO_CFG0[7:2])];
          end else if (paddr[1:0] == 2'h0 && widx >= dio_pkg::OFF_AO_VAL0[7:2]
                       && widx < 6'(dio_pkg::OFF_AO_VAL0[7:2] + dio_pkg::N_AO)) begin
            rd_val = {16'h0000, s_r.ao_out[2'(widx - dio_pkg::OFF_AO_VAL0[7:2])]};
          end else begin
            hit = 1'b0;
          end
        end
      endcase

      // one wait state so that read data and pready come from flip-flops
      if (psel && penable && !s_r.pready) begin
        s_nxt.pready = 1'b1;
        s_nxt.pslverr = !hit;
        s_nxt.prdata = rd_en && hit ? rd_val : 32'h0000_0000;
      end else begin
        s_nxt.pready = 1'b0;
        s_nxt.pslverr = 1'b0;
      end

      if (wr_en && hit) begin
        case (paddr[7:0])
          dio_pkg::OFF_CTRL: s_nxt.ctrl = pwdata[3:0];
          dio_pkg::OFF_STATUS: begin
            if (pwdata[dio_pkg::ST_FAULT]) begin
              s_nxt.fault = 1'b0;
            end
          end
          dio_pkg::OFF_RO_OVR: begin
            s_nxt.ro_ovr_en = pwdata[dio_pkg::N_RO-1:0];
            s_nxt.ro_ovr_val = pwdata[dio_pkg::OVR_VAL_LSB +: dio_pkg::N_RO];
          end
          default: begin
            if (widx >= dio_pkg::OFF_RO_PTR0[7:2] && widx < dio_pkg::OFF_RO_OVR[7:2]) begin
              s_nxt.ro_ptr[4'(widx - dio_pkg::OFF_RO_PTR0[7:2])] = pwdata;
            end else if (widx >= dio_pkg::OFF_AO_CFG0[7:2]
                         && widx < dio_pkg::OFF_AO_VAL0[7:2]) begin
              s_nxt.ao_cfg[2'(widx - dio_pkg::OFF_AO_CFG0[7:2])] = pwdata;
            end
          end
        endcase
      end

      // set wins over a same-cycle clear
      if ((ext_dio_on || ext_ao_on) && !s_r.link_sync[1]) begin
        s_nxt.fault = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= ST_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign relay_output = s_r.ro_out;
  assign analogue_output = s_r.ao_out;
  assign extension_link_lost_fault = s_r.fault;
  assign config_warning = s_r.warn;
endmodule : dio_map

// [testbench/dio_field_model.sv]
// field side: contacts, extension inputs and link health
// assumes requests from the bench; pins settle LAG cycles later, like slow contacts
`timescale 1ns/1ps
module dio_field_model #(
  parameter int LAG = 3
) (
  input wire logic pclk,
  input wire logic [6:0] contact_req,
  input wire logic [8:0] ext_req,
  input wire logic link_req,
  output logic [6:0] discrete_input,
  output logic [8:0] extension_input,
  output logic ext_link_ok
);
  logic [LAG-1:0][16:0] pipe_r;
  initial pipe_r = '0;
  always @(posedge pclk) begin
    pipe_r <= {pipe_r[LAG-2:0], link_req, ext_req, contact_req};
  end
  // seven standard, nine extension contacts
  assign {ext_link_ok, extension_input, discrete_input} = pipe_r[LAG-1];
endmodule : dio_field_model

// [testbench/dio_map_chk.sv]
// checker for dio_map: apb answer, tick grid of outputs, link fault flag
// assumes the bench holds ce high except in t_freeze; helper counters mirror the tick grid
`timescale 1ns/1ps
module dio_map_chk #(
  parameter int unsigned AO_CYC = 24,
  parameter int unsigned RO_CYC = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ext_link_ok,
  input wire logic [dio_pkg::N_RO-1:0] relay_output,
  input wire dio_pkg::dio_ao_vals_t analogue_output,
  input wire logic extension_link_lost_fault
);
  int unsigned ro_cnt_r;
  int unsigned ao_cnt_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ro_cnt_r <= 0;
      ao_cnt_r <= 0;
    end else if (ce) begin
      ro_cnt_r <= (ro_cnt_r == RO_CYC - 1) ? 0 : ro_cnt_r + 1;
      ao_cnt_r <= (ao_cnt_r == AO_CYC - 1) ? 0 : ao_cnt_r + 1;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("no answer one cycle after access");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  unmapped_err_a: assert property (psel && penable && !pready && !pwrite && paddr == 8'h38
    |=> pslverr && prdata == 32'h0) else $error("unmapped read not refused");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  relay_hold_a: assert property (!$stable(relay_output) |-> ro_cnt_r == 0)
    else $error("relay changed off its tick");
  ao_hold_a: assert property (!$stable(analogue_output[1:0]) |-> ao_cnt_r == 0)
    else $error("analogue output changed off its tick");
  fault_rise_a: assert property ($rose(extension_link_lost_fault) |-> !$past(ext_link_ok, 3))
    else $error("fault rose without link loss");
  fault_sticky_a: assert property (extension_link_lost_fault
    && !(psel && penable && pready && pwrite && paddr == 8'h0C) |=> extension_link_lost_fault)
    else $error("fault dropped without clear");
  cover property (pslverr);
  cover property ($rose(extension_link_lost_fault));
  cover property (!$stable(relay_output));
endmodule : dio_map_chk
bind dio_map dio_map_chk #(.AO_CYC(AO_CYC), .RO_CYC(RO_CYC)) chk (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ext_link_ok(ext_link_ok), .relay_output(relay_output),
  .analogue_output(analogue_output), .extension_link_lost_fault(extension_link_lost_fault));

// [testbench/drive_io_sampling_and_mapping_test.sv]
// bench for dio_map with short tick counts and a field model
// assumes ce held high except in t_freeze; apb master waits for pready under a bound
`timescale 1ns/1ps
module drive_io_sampling_and_mapping_test;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, fault, warn, link_req = 1;
  logic [6:0] di, contact_req = '0;
  logic [8:0] ei, ext_req = '0, relays;
  logic ok;
  dio_pkg::dio_words_t st = '0;
  dio_pkg::dio_qty_t qty = '0;
  dio_pkg::dio_ao_vals_t ao;
  int fail_count = 0, checked = 0;
  always #20 pclk = ~pclk;
  dio_map #(.STD_DI_CYC(6), .EXT_DI_CYC(20), .AO_CYC(24), .AO_TEMP_CYC(100), .RO_CYC(10)) DUT (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .discrete_input(di), .extension_input(ei), .ext_link_ok(ok),
    .drive_status(st), .drive_qty(qty), .relay_output(relays), .analogue_output(ao),
    .extension_link_lost_fault(fault), .config_warning(warn));
  dio_field_model #(.LAG(3)) field (.pclk(pclk), .contact_req(contact_req), .ext_req(ext_req),
    .link_req(link_req), .discrete_input(di), .extension_input(ei), .ext_link_ok(ok));
  task final_report;
    if (fail_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", n, e, g);
      fail_count++;
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  // one idle edge first, so back-to-back calls never assign psel twice in a step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      final_report;
    end
    // taken at the edge that samples pready high, released right after it
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task rd(input string n, input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(n, x, q);
  endtask : rd
  task ao1_step(input logic [15:0] x);
    logic [15:0] o;
    int k;
    o = ao[1];
    k = 0;
    while (ao[1] === o && k < 30) begin @(negedge pclk); k++; end
    if (k >= 30) begin
      fail_count++;
      final_report;
    end
    chk("ao1 filtered", {16'h0, x}, {16'h0, ao[1]});
  endtask : ao1_step
  task t_defaults;
    rd("relay one source", 8'h10, 32'h0003_0D06);
    rd("relay two source", 8'h14, 32'h0003_0202);
    rd("relay three source", 8'h18, 32'h8003_0203);
    st[13][6] <= 1'b1; st[2][2] <= 1'b1;
    cyc(22);
    chk("default relays", 32'h7, {29'h0, relays[2:0]});
    st[2][3] <= 1'b1;
    cyc(22);
    chk("fault relay", 32'h3, {29'h0, relays[2:0]});
  endtask : t_defaults
  task t_refuse;
    logic [31:0] q;
    logic e;
    apb(1'b0, 8'h38, 32'h0, q, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
    wr(8'h00, 32'h7F);
    rd("read only inputs", 8'h00, 32'h0);
  endtask : t_refuse
  task t_inputs;
    contact_req <= 7'h41;
    cyc(20);
    rd("input status", 8'h00, 32'h41);
    wr(8'h10, 32'h8001_1100);
    wr(8'h14, 32'h0001_1106);
    cyc(22);
    chk("input relays", 32'h2, {30'h0, relays[1:0]});
  endtask : t_inputs
  task t_ext;
    wr(8'h08, 32'h1);
    ext_req <= 9'h101;
    cyc(45);
    rd("ext status", 8'h04, 32'h101);
    wr(8'h1C, 32'h0001_2808);
    wr(8'h34, 32'h0000_0002);
    cyc(22);
    chk("ext relay", 32'h1, {31'h0, relays[3]});
    chk("written relay", 32'h0, {31'h0, relays[1]});
  endtask : t_ext
  task t_ao;
    for (int k = 0; k < 6; k++) qty[k] <= 16'((k + 1) * 256);
    for (int k = 0; k < 6; k++) begin
      wr(8'h40, 32'(k));
      cyc(50);
      chk("ao source", 32'((k + 1) * 256), {16'h0, ao[0]});
    end
    wr(8'h44, 32'h8);
    cyc(50);
    chk("ao inverted", 32'hFF00, {16'h0, ao[1]});
    rd("ao value", 8'h50, 32'h0600);
    wr(8'h40, 32'h1234_0100);
    cyc(50);
    chk("ao written", 32'h1234, {16'h0, ao[0]});
    wr(8'h44, 32'h10);
    ao1_step(16'h0000);
    ao1_step(16'h0080);
    wr(8'h08, 32'h3);
    wr(8'h48, 32'h0);
    cyc(50);
    chk("ext ao", 32'h0100, {16'h0, ao[2]});
  endtask : t_ao
  task t_fault;
    logic [31:0] q;
    logic e;
    link_req <= 1'b0;
    cyc(8);
    chk("link fault", 32'h1, {31'h0, fault});
    link_req <= 1'b1;
    cyc(6);
    apb(1'b0, 8'h0C, 32'h0, q, e);
    chk("fault status", 32'h1, {31'h0, q[0]});
    wr(8'h0C, 32'h1);
    cyc(1);
    chk("fault cleared", 32'h0, {31'h0, fault});
  endtask : t_fault
  task t_warn;
    chk("warning idle", 32'h0, {31'h0, warn});
    wr(8'h08, 32'h0);
    cyc(2);
    chk("warning raised", 32'h1, {31'h0, warn});
  endtask : t_warn
  // ce low must freeze the link fault even with the link gone
  task t_freeze;
    wr(8'h08, 32'h1);
    ce <= 1'b0;
    link_req <= 1'b0;
    cyc(12);
    chk("frozen fault", 32'h0, {31'h0, fault});
    ce <= 1'b1;
    cyc(8);
    chk("thawed fault", 32'h1, {31'h0, fault});
  endtask : t_freeze
  initial begin
    cyc(5);
    presetn <= 1'b1;
    t_defaults;
    t_refuse;
    t_inputs;
    t_ext;
    t_ao;
    t_fault;
    t_warn;
    t_freeze;
    final_report;
  end
endmodule : drive_io_sampling_and_mapping_test
